// *** include/ftg_pkg.sv ***
// ftg_pkg: constants shared by the slot-1 tdd control glue
// assumes one core clock of CLK_HZ; no software-visible registers
`default_nettype none

package ftg_pkg;

    // core clock
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned CLK_MHZ         = CLK_HZ / 1000000;

    // system reference frequency and accumulator sizing
    localparam int unsigned SYSREF_HZ       = 120000;
    localparam int unsigned SYSREF_STEP     = 2 * SYSREF_HZ;
    localparam int unsigned SYSREF_ACC_W    = 25;

    // width of every edge-marking pulse, least time rounded up
    localparam int unsigned PULSE_NS        = 200;
    localparam int unsigned PULSE_CYCLES    = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_CNT_W     = 3;

    // bus widths
    localparam int unsigned SP_GPIO_W       = 18;
    localparam int unsigned GP_BANK_W       = 8;
    localparam int unsigned CONDITION_W     = 2;

    // reset values
    localparam logic        SELECT_IDLE_N   = 1'h1;
    localparam logic        OE_IDLE_N       = 1'h1;

    // tdd period tracker
    typedef enum logic [1:0] {
        PER_IDLE,
        PER_DOWNLINK,
        PER_UPLINK
    } ftg_period_e;

endpackage : ftg_pkg

`default_nettype wire

// *** hdl/ftg_sysref_gen.sv ***
// ftg_sysref_gen: differential periodic system reference
// assumes a free-running clock of CLK_HZ and async active-high reset
`timescale 1ns/100ps
`default_nettype none

module ftg_sysref_gen
    import ftg_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST,
    output var  logic REF_P,
    output var  logic REF_N
);

    logic [SYSREF_ACC_W-1:0] acc_r;
    logic [SYSREF_ACC_W-1:0] acc_nxt;
    logic                    ph_r;
    logic                    ph_nxt;

    // phase accumulator: toggles twice per reference period, exact on average
    always_comb begin
        acc_nxt = acc_r + SYSREF_ACC_W'(SYSREF_STEP);
        ph_nxt  = ph_r;
        if (acc_nxt >= SYSREF_ACC_W'(CLK_HZ)) begin
            acc_nxt = acc_nxt - SYSREF_ACC_W'(CLK_HZ);
            ph_nxt  = ~ph_r;
        end
    end

    // complementary pair from flops, no skew from an inverter
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_r <= '0;
            ph_r  <= 1'h0;
            REF_P <= 1'h0;
            REF_N <= 1'h1;
        end else begin
            acc_r <= acc_nxt;
            ph_r  <= ph_nxt;
            REF_P <= ph_nxt;
            REF_N <= ~ph_nxt;
        end
    end

endmodule // ftg_sysref_gen

`default_nettype wire

// *** hdl/ftg_glue.sv ***
// ftg_glue: slot-1 front-end card glue, tdd control, gpio bridging, selects
// assumes all pins are asynchronous to CORE_CLK; config inputs are same-clock
//
// Contract
// - drive a 120 kHz differential system reference toward the card buffer.
// - bridge SoC signal-processing gpio lines to card gpio lines per direction.
// - tx capture output rises at downlink time.
// - rx capture output rises at uplink time.
// - original mode: receive-on rises at uplink start, also ending downlink.
// - revised mode: receive-on is high across the uplink period.
// - original mode: transmit-on rises at downlink start.
// - revised mode: transmit-on is high across the transmit period.
// - original mode: receive-off rises at uplink end; unused when revised.
// - power-amp enable output timed with the transmit schedule.
// - rf path switch steers antenna to transmit during downlink.
// - separate selects for slot-1 clock chip, slot-2 converter, slot-2 clock chip.
// - eight-bit slot-1 gp bank, each bit drivable or readable.
// - all sequential logic runs from the core clock.
// - system reference is derived from the core clock by a phase accumulator.
`timescale 1ns/100ps
`default_nettype none

module ftg_glue
    import ftg_pkg::*;
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST,
    // tdd schedule levels from the soc event pins
    input  wire logic                   DOWNLINK_PERIOD,
    input  wire logic                   UPLINK_PERIOD,
    input  wire logic                   REVISED_FRONT_END,
    // tdd outputs to the card
    output var  logic                   SLOT1_TX_CAPTURE_PULSE,
    output var  logic                   SLOT1_RX_CAPTURE_PULSE,
    output var  logic                   SLOT1_RECEIVE_ON_PULSE,
    output var  logic                   SLOT1_TRANSMIT_ON_PULSE,
    output var  logic                   SLOT1_RECEIVE_OFF_PULSE,
    output var  logic                   POWER_AMP_ENABLE,
    output var  logic                   RF_PATH_SWITCH,
    // system reference
    output var  logic                   SYS_REFERENCE_OUT_P,
    output var  logic                   SYS_REFERENCE_OUT_N,
    // chip select requests from the soc, active low
    input  wire logic                   CLOCKCHIP1_REQ_N,
    input  wire logic                   CONVERTER2_REQ_N,
    input  wire logic                   CLOCKCHIP2_REQ_N,
    output var  logic                   SLOT1_CLOCKCHIP_SELECT_N,
    output var  logic                   SLOT2_CONVERTER_SELECT_N,
    output var  logic                   SLOT2_CLOCKCHIP_SELECT_N,
    // card condition
    input  wire logic [CONDITION_W-1:0] SLOT1_CARD_CONDITION,
    output var  logic [CONDITION_W-1:0] CARD_CONDITION_SAMPLED,
    // soc side of the signal-processing gpio bridge
    input  wire logic [SP_GPIO_W-1:0]   SP_GPIO_SOC_TO_CARD,
    input  wire logic [SP_GPIO_W-1:0]   SOC_SIGNAL_PROC_GPIO_I,
    output var  logic [SP_GPIO_W-1:0]   SOC_SIGNAL_PROC_GPIO_O,
    output var  logic [SP_GPIO_W-1:0]   SOC_SIGNAL_PROC_GPIO_OE_N,
    // card side of the signal-processing gpio bridge
    input  wire logic [SP_GPIO_W-1:0]   CARD_PROC_GPIO_I,
    output var  logic [SP_GPIO_W-1:0]   CARD_PROC_GPIO_O,
    output var  logic [SP_GPIO_W-1:0]   CARD_PROC_GPIO_OE_N,
    // slot-1 general purpose bank
    input  wire logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_DRIVE,
    input  wire logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_WDATA,
    output var  logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_RDATA,
    input  wire logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_I,
    output var  logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_O,
    output var  logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_OE_N
);

    // next count of a fixed-width pulse: reload on fire, else run down
    function automatic logic [PULSE_CNT_W-1:0] pulse_next(
        input logic [PULSE_CNT_W-1:0] cnt,
        input logic                   fire
    );
        logic [PULSE_CNT_W-1:0] res;
        res = cnt;
        if (fire) begin
            res = PULSE_CNT_W'(PULSE_CYCLES);
        end else if (cnt != '0) begin
            res = cnt - PULSE_CNT_W'(1);
        end
        return res;
    endfunction

    // two-flop synchronisers for every pin input
    logic                   dl_m_r,   dl_s_r;
    logic                   ul_m_r,   ul_s_r;
    logic                   rev_m_r,  rev_s_r;
    logic [2:0]             cs_m_r,   cs_s_r;
    logic [CONDITION_W-1:0] cond_m_r, cond_s_r;
    logic [SP_GPIO_W-1:0]   soc_m_r,  soc_s_r;
    logic [SP_GPIO_W-1:0]   card_m_r, card_s_r;
    logic [GP_BANK_W-1:0]   bank_m_r, bank_s_r;

    // first stage feeds only the second stage
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dl_m_r   <= 1'h0;
            dl_s_r   <= 1'h0;
            ul_m_r   <= 1'h0;
            ul_s_r   <= 1'h0;
            rev_m_r  <= 1'h0;
            rev_s_r  <= 1'h0;
            cs_m_r   <= 3'h7;
            cs_s_r   <= 3'h7;
            cond_m_r <= '0;
            cond_s_r <= '0;
            soc_m_r  <= '0;
            soc_s_r  <= '0;
            card_m_r <= '0;
            card_s_r <= '0;
            bank_m_r <= '0;
            bank_s_r <= '0;
        end else begin
            dl_m_r   <= DOWNLINK_PERIOD;
            dl_s_r   <= dl_m_r;
            ul_m_r   <= UPLINK_PERIOD;
            ul_s_r   <= ul_m_r;
            rev_m_r  <= REVISED_FRONT_END;
            rev_s_r  <= rev_m_r;
            cs_m_r   <= {CLOCKCHIP2_REQ_N, CONVERTER2_REQ_N, CLOCKCHIP1_REQ_N};
            cs_s_r   <= cs_m_r;
            cond_m_r <= SLOT1_CARD_CONDITION;
            cond_s_r <= cond_m_r;
            soc_m_r  <= SOC_SIGNAL_PROC_GPIO_I;
            soc_s_r  <= soc_m_r;
            card_m_r <= CARD_PROC_GPIO_I;
            card_s_r <= card_m_r;
            bank_m_r <= SLOT1_GP_BANK_I;
            bank_s_r <= bank_m_r;
        end
    end

    // tdd period tracker and edge-marking pulse counters
    ftg_period_e            per_r,   per_nxt;
    logic                   rev_r,   rev_nxt;
    logic [PULSE_CNT_W-1:0] txcap_r, txcap_nxt;
    logic [PULSE_CNT_W-1:0] rxcap_r, rxcap_nxt;
    logic [PULSE_CNT_W-1:0] rxon_r,  rxon_nxt;
    logic [PULSE_CNT_W-1:0] rf_path_switch_r,  rf_path_switch_nxt;
    logic [PULSE_CNT_W-1:0] rxoff_r, rxoff_nxt;
    logic                   dl_start;
    logic                   ul_start;
    logic                   ul_end;
    logic                   txcap_o, rxcap_o, rxon_o, rf_path_switch_o, rxoff_o, pa_o, sw_o;

    // downlink wins if the schedule asks for both periods at once
    always_comb begin
        per_nxt = per_r;
        case (per_r)
            PER_IDLE: begin
                if (dl_s_r) begin
                    per_nxt = PER_DOWNLINK;
                end else if (ul_s_r) begin
                    per_nxt = PER_UPLINK;
                end
            end
            PER_DOWNLINK: begin
                if (!dl_s_r) begin
                    per_nxt = ul_s_r ? PER_UPLINK : PER_IDLE;
                end
            end
            PER_UPLINK: begin
                if (dl_s_r) begin
                    per_nxt = PER_DOWNLINK;
                end else if (!ul_s_r) begin
                    per_nxt = PER_IDLE;
                end
            end
            default: begin
                per_nxt = PER_IDLE;
            end
        endcase
    end

    // period boundaries seen on the state change
    assign dl_start = (per_nxt == PER_DOWNLINK) && (per_r != PER_DOWNLINK);
    assign ul_start = (per_nxt == PER_UPLINK) && (per_r != PER_UPLINK);
    assign ul_end   = (per_r == PER_UPLINK) && (per_nxt != PER_UPLINK);

    // signalling style changes only while idle, so no level is cut short
    always_comb begin
        rev_nxt = (per_r == PER_IDLE && per_nxt == PER_IDLE) ? rev_s_r : rev_r;
    end

    // pulse counters
    always_comb begin
        txcap_nxt = pulse_next(txcap_r, dl_start);
        rxcap_nxt = pulse_next(rxcap_r, ul_start);
        rxon_nxt  = pulse_next(rxon_r,  ul_start);
        rf_path_switch_nxt  = pulse_next(rf_path_switch_r,  dl_start);
        rxoff_nxt = pulse_next(rxoff_r, ul_end && !rev_nxt);
    end

    // output values: receive-on and transmit-on pulse in original mode, follow levels in revised mode
    always_comb begin
        txcap_o = (txcap_nxt != '0);
        rxcap_o = (rxcap_nxt != '0);
        if (rev_nxt) begin
            rxon_o  = (per_nxt == PER_UPLINK);
            rf_path_switch_o  = (per_nxt == PER_DOWNLINK);
            rxoff_o = 1'h0;
        end else begin
            rxon_o  = (rxon_nxt != '0);
            rf_path_switch_o  = (rf_path_switch_nxt != '0);
            rxoff_o = (rxoff_nxt != '0);
        end
        pa_o = (per_nxt == PER_DOWNLINK);
        sw_o = (per_nxt == PER_DOWNLINK);
    end

    // tdd registers; outputs change only on clock edges and at the asynchronous reset
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            per_r                   <= PER_IDLE;
            rev_r                   <= 1'h0;
            txcap_r                 <= '0;
            rxcap_r                 <= '0;
            rxon_r                  <= '0;
            rf_path_switch_r                  <= '0;
            rxoff_r                 <= '0;
            SLOT1_TX_CAPTURE_PULSE  <= 1'h0;
            SLOT1_RX_CAPTURE_PULSE  <= 1'h0;
            SLOT1_RECEIVE_ON_PULSE  <= 1'h0;
            SLOT1_TRANSMIT_ON_PULSE <= 1'h0;
            SLOT1_RECEIVE_OFF_PULSE <= 1'h0;
            POWER_AMP_ENABLE        <= 1'h0;
            RF_PATH_SWITCH          <= 1'h0;
        end else begin
            per_r                   <= per_nxt;
            rev_r                   <= rev_nxt;
            txcap_r                 <= txcap_nxt;
            rxcap_r                 <= rxcap_nxt;
            rxon_r                  <= rxon_nxt;
            rf_path_switch_r                  <= rf_path_switch_nxt;
            rxoff_r                 <= rxoff_nxt;
            SLOT1_TX_CAPTURE_PULSE  <= txcap_o;
            SLOT1_RX_CAPTURE_PULSE  <= rxcap_o;
            SLOT1_RECEIVE_ON_PULSE  <= rxon_o;
            SLOT1_TRANSMIT_ON_PULSE <= rf_path_switch_o;
            SLOT1_RECEIVE_OFF_PULSE <= rxoff_o;
            POWER_AMP_ENABLE        <= pa_o;
            RF_PATH_SWITCH          <= sw_o;
        end
    end

    // selects, condition and gpio paths
    logic [2:0]             cs_nxt;
    logic [CONDITION_W-1:0] cond_nxt;
    logic [SP_GPIO_W-1:0]   soc_o_nxt,  soc_oe_nxt;
    logic [SP_GPIO_W-1:0]   card_o_nxt, card_oe_nxt;
    logic [GP_BANK_W-1:0]   bank_o_nxt, bank_oe_nxt, bank_rd_nxt;

    // each side drives only the lines configured as its outputs
    always_comb begin
        cs_nxt      = cs_s_r;
        cond_nxt    = cond_s_r;
        card_o_nxt  = soc_s_r;
        card_oe_nxt = ~SP_GPIO_SOC_TO_CARD;
        soc_o_nxt   = card_s_r;
        soc_oe_nxt  = SP_GPIO_SOC_TO_CARD;
        bank_o_nxt  = SLOT1_GP_BANK_WDATA;
        bank_oe_nxt = ~SLOT1_GP_BANK_DRIVE;
        bank_rd_nxt = (SLOT1_GP_BANK_DRIVE & SLOT1_GP_BANK_WDATA)
                    | (~SLOT1_GP_BANK_DRIVE & bank_s_r);
    end

    // registered pin drivers; idle with selects high and enables off
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SLOT1_CLOCKCHIP_SELECT_N  <= SELECT_IDLE_N;
            SLOT2_CONVERTER_SELECT_N  <= SELECT_IDLE_N;
            SLOT2_CLOCKCHIP_SELECT_N  <= SELECT_IDLE_N;
            CARD_CONDITION_SAMPLED    <= '0;
            SOC_SIGNAL_PROC_GPIO_O    <= '0;
            SOC_SIGNAL_PROC_GPIO_OE_N <= {SP_GPIO_W{OE_IDLE_N}};
            CARD_PROC_GPIO_O          <= '0;
            CARD_PROC_GPIO_OE_N       <= {SP_GPIO_W{OE_IDLE_N}};
            SLOT1_GP_BANK_O           <= '0;
            SLOT1_GP_BANK_OE_N        <= {GP_BANK_W{OE_IDLE_N}};
            SLOT1_GP_BANK_RDATA       <= '0;
        end else begin
            SLOT1_CLOCKCHIP_SELECT_N  <= cs_nxt[0];
            SLOT2_CONVERTER_SELECT_N  <= cs_nxt[1];
            SLOT2_CLOCKCHIP_SELECT_N  <= cs_nxt[2];
            CARD_CONDITION_SAMPLED    <= cond_nxt;
            SOC_SIGNAL_PROC_GPIO_O    <= soc_o_nxt;
            SOC_SIGNAL_PROC_GPIO_OE_N <= soc_oe_nxt;
            CARD_PROC_GPIO_O          <= card_o_nxt;
            CARD_PROC_GPIO_OE_N       <= card_oe_nxt;
            SLOT1_GP_BANK_O           <= bank_o_nxt;
            SLOT1_GP_BANK_OE_N        <= bank_oe_nxt;
            SLOT1_GP_BANK_RDATA       <= bank_rd_nxt;
        end
    end

    // system reference generator on the core clock
    ftg_sysref_gen u_sysref (
        .CLK   (CORE_CLK),
        .RST   (RST),
        .REF_P (SYS_REFERENCE_OUT_P),
        .REF_N (SYS_REFERENCE_OUT_N)
    );

endmodule // ftg_glue

`default_nettype wire

// *** bench/ftg_glue_properties.sv ***
// ftg_glue_properties: port timing checks for the slot-1 tdd control glue
// assumes one core clock and an async active-high reset
`timescale 1ns/100ps
`default_nettype none

module ftg_glue_chk
    import ftg_pkg::*;
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST,
    input  wire logic                   SLOT1_TX_CAPTURE_PULSE,
    input  wire logic                   SLOT1_RX_CAPTURE_PULSE,
    input  wire logic                   SLOT1_RECEIVE_ON_PULSE,
    input  wire logic                   SLOT1_TRANSMIT_ON_PULSE,
    input  wire logic                   POWER_AMP_ENABLE,
    input  wire logic                   RF_PATH_SWITCH,
    input  wire logic                   SYS_REFERENCE_OUT_P,
    input  wire logic                   SYS_REFERENCE_OUT_N,
    input  wire logic                   CLOCKCHIP1_REQ_N,
    input  wire logic                   SLOT1_CLOCKCHIP_SELECT_N,
    input  wire logic [CONDITION_W-1:0] SLOT1_CARD_CONDITION,
    input  wire logic [CONDITION_W-1:0] CARD_CONDITION_SAMPLED,
    input  wire logic [SP_GPIO_W-1:0]   SP_GPIO_SOC_TO_CARD,
    input  wire logic [SP_GPIO_W-1:0]   SOC_SIGNAL_PROC_GPIO_OE_N,
    input  wire logic [SP_GPIO_W-1:0]   CARD_PROC_GPIO_OE_N,
    input  wire logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_DRIVE,
    input  wire logic [GP_BANK_W-1:0]   SLOT1_GP_BANK_OE_N
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    logic [7:0] ref_cnt_r;
    logic [7:0] ref_cnt_nxt;
    logic       ref_prev_r;
    logic       ref_seen_r;

    // cycles since the last reference edge
    always_comb begin
        ref_cnt_nxt = (SYS_REFERENCE_OUT_P != ref_prev_r) ? 8'h01 : ref_cnt_r + 8'h01;
    end

    // register the counter, arm after the first edge
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ref_cnt_r  <= 8'h00;
            ref_prev_r <= 1'h0;
            ref_seen_r <= 1'h0;
        end else begin
            ref_cnt_r  <= ref_cnt_nxt;
            ref_prev_r <= SYS_REFERENCE_OUT_P;
            ref_seen_r <= ref_seen_r | (SYS_REFERENCE_OUT_P != ref_prev_r);
        end
    end

    chk_ref_legs: assert property (SYS_REFERENCE_OUT_N == !SYS_REFERENCE_OUT_P)
        else $error("reference legs not complementary");
    chk_ref_half: assert property (
        (ref_seen_r && SYS_REFERENCE_OUT_P != ref_prev_r) |-> ref_cnt_r inside {[8'h53:8'h54]})
        else $error("reference half period out of range");
    chk_ref_stuck: assert property (ref_seen_r |-> ref_cnt_r <= 8'h54)
        else $error("reference stopped toggling");
    chk_txcap_width: assert property (
        $rose(SLOT1_TX_CAPTURE_PULSE) |-> SLOT1_TX_CAPTURE_PULSE [*4] ##1 !SLOT1_TX_CAPTURE_PULSE)
        else $error("tx capture pulse width wrong");
    chk_rxcap_width: assert property (
        $rose(SLOT1_RX_CAPTURE_PULSE) |-> SLOT1_RX_CAPTURE_PULSE [*4] ##1 !SLOT1_RX_CAPTURE_PULSE)
        else $error("rx capture pulse width wrong");
    chk_tx_start: assert property (
        $rose(SLOT1_TX_CAPTURE_PULSE) |-> $rose(SLOT1_TRANSMIT_ON_PULSE) && $rose(POWER_AMP_ENABLE))
        else $error("downlink start outputs not aligned");
    chk_rx_start: assert property (
        $rose(SLOT1_RX_CAPTURE_PULSE) |-> $rose(SLOT1_RECEIVE_ON_PULSE) && !RF_PATH_SWITCH)
        else $error("uplink start outputs not aligned");
    chk_pa_switch: assert property (POWER_AMP_ENABLE == RF_PATH_SWITCH)
        else $error("power amp and rf switch disagree");
    chk_sel_follow: assert property (
        (CLOCKCHIP1_REQ_N == $past(CLOCKCHIP1_REQ_N)) [*6] |-> SLOT1_CLOCKCHIP_SELECT_N == CLOCKCHIP1_REQ_N)
        else $error("clock chip select does not follow request");
    chk_cond_follow: assert property (
        (SLOT1_CARD_CONDITION == $past(SLOT1_CARD_CONDITION)) [*6] |-> CARD_CONDITION_SAMPLED == SLOT1_CARD_CONDITION)
        else $error("sampled condition does not follow card");
    chk_gpio_one_side: assert property (&(CARD_PROC_GPIO_OE_N | SOC_SIGNAL_PROC_GPIO_OE_N))
        else $error("gpio line driven toward both sides");
    chk_gpio_dir: assert property (
        (SP_GPIO_SOC_TO_CARD == $past(SP_GPIO_SOC_TO_CARD)) [*3] |-> CARD_PROC_GPIO_OE_N == ~SP_GPIO_SOC_TO_CARD)
        else $error("card gpio enables do not match direction");
    chk_bank_dir: assert property (
        (SLOT1_GP_BANK_DRIVE == $past(SLOT1_GP_BANK_DRIVE)) [*3] |-> SLOT1_GP_BANK_OE_N == ~SLOT1_GP_BANK_DRIVE)
        else $error("bank enables do not match drive mask");
endmodule // ftg_glue_chk

`default_nettype wire

// *** bench/ftg_card_model.sv ***
// ftg_card_model: behavioural front-end card on the slot-1 connector
// assumes the glue pin triplets; the card drives every line the glue releases
`timescale 1ns/100ps
`default_nettype none

module ftg_card_model
    import ftg_pkg::*;
(
    input  wire logic [SP_GPIO_W-1:0]   gpio_o,
    input  wire logic [SP_GPIO_W-1:0]   gpio_oe_n,
    input  wire logic [SP_GPIO_W-1:0]   gpio_val,
    output var  logic [SP_GPIO_W-1:0]   gpio_i,
    input  wire logic [GP_BANK_W-1:0]   bank_o,
    input  wire logic [GP_BANK_W-1:0]   bank_oe_n,
    input  wire logic [GP_BANK_W-1:0]   bank_val,
    output var  logic [GP_BANK_W-1:0]   bank_i,
    input  wire logic [CONDITION_W-1:0] cond_val,
    output var  logic [CONDITION_W-1:0] cond
);
    // wire level: glue value where it drives, card value elsewhere
    assign gpio_i = (gpio_o & ~gpio_oe_n) | (gpio_val & gpio_oe_n);
    assign bank_i = (bank_o & ~bank_oe_n) | (bank_val & bank_oe_n);
    // card reports its operating condition
    assign cond = cond_val;
endmodule // ftg_card_model

`default_nettype wire

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for the slot-1 tdd control glue
// assumes ftg_pkg, ftg_glue, the card model and the checker compiled first
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import ftg_pkg::*;
;
    logic                   clk;
    logic                   rst, dnlk, uplk, rev;
    logic                   txc, rxc, recv_on, xmit_on, recv_off, pa, sw, refp, refn;
    logic [2:0]             rq, sel;
    logic [CONDITION_W-1:0] cond, conds, cv;
    logic [SP_GPIO_W-1:0]   dir, sv, cvl, s_i, s_o, s_oe, c_i, c_o, c_oe;
    logic [GP_BANK_W-1:0]   bdrv, bwd, brd, bv, b_i, b_o, b_oe;
    int                     err_total, num_checks;

    // core clock, 50 ns period
    always #25 clk = ~clk;

    // soc side wire level
    assign s_i = (s_o & ~s_oe) | (sv & s_oe);

    ftg_glue DUT (
        .CORE_CLK(clk), .RST(rst), .DOWNLINK_PERIOD(dnlk), .UPLINK_PERIOD(uplk), .REVISED_FRONT_END(rev),
        .SLOT1_TX_CAPTURE_PULSE(txc), .SLOT1_RX_CAPTURE_PULSE(rxc), .SLOT1_RECEIVE_ON_PULSE(recv_on),
        .SLOT1_TRANSMIT_ON_PULSE(xmit_on), .SLOT1_RECEIVE_OFF_PULSE(recv_off), .POWER_AMP_ENABLE(pa),
        .RF_PATH_SWITCH(sw), .SYS_REFERENCE_OUT_P(refp), .SYS_REFERENCE_OUT_N(refn),
        .CLOCKCHIP1_REQ_N(rq[0]), .CONVERTER2_REQ_N(rq[1]), .CLOCKCHIP2_REQ_N(rq[2]),
        .SLOT1_CLOCKCHIP_SELECT_N(sel[0]), .SLOT2_CONVERTER_SELECT_N(sel[1]), .SLOT2_CLOCKCHIP_SELECT_N(sel[2]),
        .SLOT1_CARD_CONDITION(cond), .CARD_CONDITION_SAMPLED(conds), .SP_GPIO_SOC_TO_CARD(dir),
        .SOC_SIGNAL_PROC_GPIO_I(s_i), .SOC_SIGNAL_PROC_GPIO_O(s_o), .SOC_SIGNAL_PROC_GPIO_OE_N(s_oe),
        .CARD_PROC_GPIO_I(c_i), .CARD_PROC_GPIO_O(c_o), .CARD_PROC_GPIO_OE_N(c_oe),
        .SLOT1_GP_BANK_DRIVE(bdrv), .SLOT1_GP_BANK_WDATA(bwd), .SLOT1_GP_BANK_RDATA(brd),
        .SLOT1_GP_BANK_I(b_i), .SLOT1_GP_BANK_O(b_o), .SLOT1_GP_BANK_OE_N(b_oe)
    );

    ftg_card_model u_card (
        .gpio_o(c_o), .gpio_oe_n(c_oe), .gpio_val(cvl), .gpio_i(c_i), .bank_o(b_o),
        .bank_oe_n(b_oe), .bank_val(bv), .bank_i(b_i), .cond_val(cv), .cond(cond)
    );

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    // counts, verdict and end of run
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reset in mid downlink clears outputs at once
    task automatic t_reset;
        dnlk = 1'h1;
        rq = 3'h0;
        wait_n(6);
        rst = 1'h1;
        #1;
        chk({txc, rxc, recv_on, xmit_on, recv_off, pa, sw, refp, refn, sel}, 12'h00F);
        chk({&s_oe, &c_oe, &b_oe}, 3'h7);
        wait_n(3);
        dnlk = 1'h0;
        rq = 3'h7;
        rst = 1'h0;
        wait_n(6);
    endtask

    // each select alone follows its request
    task automatic t_sel;
        for (int i = 0; i < 3; i++) begin
            rq = ~(3'h1 << i);
            wait_n(5);
            chk(sel, rq);
        end
        rq = 3'h7;
        wait_n(5);
        chk(sel, 3'h7);
    endtask

    // downlink, direct switch to uplink, uplink end
    task automatic t_tdd(input logic m);
        rev = m;
        wait_n(6);
        dnlk = 1'h1;
        wait_n(4);
        chk({txc, xmit_on, pa, sw, rxc, recv_on, recv_off}, 7'h78);
        wait_n(4);
        chk({txc, xmit_on, pa, sw}, {1'h0, m, 2'h3});
        dnlk = 1'h0;
        uplk = 1'h1;
        wait_n(4);
        chk({txc, xmit_on, pa, sw, rxc, recv_on, recv_off}, 7'h06);
        wait_n(4);
        chk({rxc, recv_on, recv_off}, {1'h0, m, 1'h0});
        uplk = 1'h0;
        wait_n(4);
        chk({recv_on, recv_off}, {1'h0, ~m});
        wait_n(4);
        chk({recv_on, recv_off}, 2'h0);
    endtask

    // gpio bridge both ways, then values flipped
    task automatic t_gpio(input logic [SP_GPIO_W-1:0] d);
        dir = d;
        sv = 18'h2A5C3;
        cvl = 18'h15A3C;
        wait_n(6);
        chk(c_oe, SP_GPIO_W'(~d));
        chk(s_oe, d);
        chk(c_o & d, sv & d);
        chk(s_o & ~d, cvl & ~d);
        sv = ~sv;
        cvl = ~cvl;
        wait_n(5);
        chk(c_o & d, sv & d);
        chk(s_o & ~d, cvl & ~d);
    endtask

    // bank: driven bits write, released bits read the pin
    task automatic t_bank(input logic [GP_BANK_W-1:0] d);
        bdrv = d;
        bwd = 8'hA5;
        bv = 8'h3C;
        wait_n(6);
        chk(b_oe, GP_BANK_W'(~d));
        chk(b_o & d, bwd & d);
        chk(brd, (bwd & d) | (bv & ~d));
    endtask

    // every condition code reaches the sampled copy
    task automatic t_cond;
        for (int v = 0; v < 4; v++) begin
            cv = v[1:0];
            wait_n(5);
            chk(conds, cv);
        end
    endtask

    // reference half periods and complementary legs
    task automatic t_ref;
        logic l;
        int   n;
        for (int k = 0; k < 4; k++) begin
            l = refp;
            n = 0;
            while (refp === l && n < 200) begin
                @(posedge clk);
                #1;
                n++;
            end
            if (k > 0) chk(n >= 83 && n <= 84, 1'h1);
            chk(refn, !refp);
        end
    endtask

    // main sequence
    initial begin
        clk = 1'h0;
        rst = 1'h1;
        {dnlk, uplk, rev} = 3'h0;
        rq = 3'h7;
        {cv, dir, sv, cvl} = '0;
        {bdrv, bwd, bv} = '0;
        err_total = 0;
        num_checks = 0;
        wait_n(3);
        rst = 1'h0;
        wait_n(4);
        t_sel();
        t_tdd(1'h0);
        t_tdd(1'h1);
        t_gpio(18'h0F0F0);
        t_gpio(18'h30F0F);
        t_bank(8'h0F);
        t_bank(8'hF0);
        t_cond();
        t_ref();
        t_reset();
        give_verdict();
    end

    // watchdog, far beyond the expected run
    initial begin
        #1000000;
        err_total++;
        give_verdict();
    end
endmodule // tb_top

bind ftg_glue ftg_glue_chk u_chk (
    .CORE_CLK, .RST, .SLOT1_TX_CAPTURE_PULSE, .SLOT1_RX_CAPTURE_PULSE, .SLOT1_RECEIVE_ON_PULSE,
    .SLOT1_TRANSMIT_ON_PULSE, .POWER_AMP_ENABLE, .RF_PATH_SWITCH, .SYS_REFERENCE_OUT_P,
    .SYS_REFERENCE_OUT_N, .CLOCKCHIP1_REQ_N, .SLOT1_CLOCKCHIP_SELECT_N, .SLOT1_CARD_CONDITION,
    .CARD_CONDITION_SAMPLED, .SP_GPIO_SOC_TO_CARD, .SOC_SIGNAL_PROC_GPIO_OE_N, .CARD_PROC_GPIO_OE_N,
    .SLOT1_GP_BANK_DRIVE, .SLOT1_GP_BANK_OE_N
);

`default_nettype wire
